/* inc/tcsc_pkg.sv */
// package: constants and types for the tightly coupled sram control block
package tcsc_pkg;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CTRL_W       = 32;
  localparam int unsigned SZ_W         = 5;
  // control word bit positions
  localparam int unsigned CTRL_DEN_BIT = 16;
  localparam int unsigned CTRL_DLD_BIT = 17;
  localparam int unsigned CTRL_IEN_BIT = 18;
  localparam int unsigned CTRL_ILD_BIT = 19;
  localparam logic [CTRL_W-1:0] CTRL_ILOAD_MASK = 32'h000C_0000;
  localparam logic [CTRL_W-1:0] CTRL_DLOAD_MASK = 32'h0003_0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET      = 32'h0000_0000;
  // size code n means 2**n bytes; 0 means no memory, 20 is one megabyte
  localparam logic [SZ_W-1:0]   SZ_MAX          = 5'h14;
  localparam logic [ADDR_W-1:0] ITCM_BASE       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET      = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {
    TCSC_SRC_EXT  = 2'b00,
    TCSC_SRC_ITCM = 2'b01,
    TCSC_SRC_DTCM = 2'b11
  } tcsc_src_t;
endpackage : tcsc_pkg

/* inc/tcsc_dec_if.sv */
// interface: carries one address and the region setup into the decoder
`timescale 1ns/10ps
interface tcsc_dec_if;
  import tcsc_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] base;
  logic [SZ_W-1:0]   size;
  logic              hit;
  modport decoder (input addr, input base, input size, output hit);
  modport user    (output addr, output base, output size, input hit);
endinterface : tcsc_dec_if

/* design/tcsc_range_dec.sv */
// module: power-of-two region match, a mask compare with no adder
`timescale 1ns/10ps
module tcsc_range_dec (
  tcsc_dec_if.decoder d
);
  import tcsc_pkg::*;
  logic [ADDR_W-1:0] mask;
  logic              legal;

  // upper address bits above the size must equal the base
  generate
    for (genvar b = 0; b < ADDR_W; b++) begin : g_mask
      assign mask[b] = (b >= int'(d.size));
    end
  endgenerate

  // a zero or oversize code maps nothing
  assign legal = (d.size != '0) && (d.size <= SZ_MAX);
  assign d.hit = legal && (((d.addr ^ d.base) & mask) == '0);
endmodule : tcsc_range_dec

/* design/tcsc_ctrl.sv */
// module: routing of core instruction and data accesses to the two tcms
`timescale 1ns/10ps
module tcsc_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  // control word and region setup
  input  wire logic [tcsc_pkg::CTRL_W-1:0] ctrl_word,
  input  wire logic [tcsc_pkg::SZ_W-1:0]   itcm_size,
  input  wire logic [tcsc_pkg::ADDR_W-1:0] dtcm_base,
  input  wire logic [tcsc_pkg::SZ_W-1:0]   dtcm_size,
  // core instruction port
  input  wire logic                        i_req,
  input  wire logic [tcsc_pkg::ADDR_W-1:0] i_addr,
  output logic      [tcsc_pkg::DATA_W-1:0] i_rdata,
  output logic                             i_ext,
  // core data port
  input  wire logic                        d_req,
  input  wire logic                        d_wr,
  input  wire logic [tcsc_pkg::ADDR_W-1:0] d_addr,
  input  wire logic [tcsc_pkg::DATA_W-1:0] d_wdata,
  input  wire logic [3:0]                  d_be,
  output logic      [tcsc_pkg::DATA_W-1:0] d_rdata,
  output logic                             d_ext,
  output logic                             d_stall,
  // instruction sram array
  output logic                             isr_cs,
  output logic                             isr_we,
  output logic      [tcsc_pkg::ADDR_W-1:0] isr_addr,
  output logic      [tcsc_pkg::DATA_W-1:0] isr_wdata,
  output logic      [3:0]                  isr_be,
  input  wire logic [tcsc_pkg::DATA_W-1:0] isr_rdata,
  // data sram array
  output logic                             dsr_cs,
  output logic                             dsr_we,
  output logic      [tcsc_pkg::ADDR_W-1:0] dsr_addr,
  output logic      [tcsc_pkg::DATA_W-1:0] dsr_wdata,
  output logic      [3:0]                  dsr_be,
  input  wire logic [tcsc_pkg::DATA_W-1:0] dsr_rdata,
  // status view of the control bits in force
  output logic                             itcm_on,
  output logic                             itcm_load,
  output logic                             dtcm_on,
  output logic                             dtcm_load
);
  import tcsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // control bits
  logic ien;
  logic ild;
  logic den;
  logic dld;

  // the control word comes from the core's own register, which sits at its reset value in reset
  assign ien = ctrl_word[CTRL_IEN_BIT];
  assign ild = ctrl_word[CTRL_ILD_BIT];
  assign den = ctrl_word[CTRL_DEN_BIT];
  assign dld = ctrl_word[CTRL_DLD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // range decode
  tcsc_dec_if i_dec ();
  tcsc_dec_if di_dec ();
  tcsc_dec_if dd_dec ();

  assign i_dec.addr  = i_addr;
  assign i_dec.base  = ITCM_BASE;
  assign i_dec.size  = itcm_size;
  assign di_dec.addr = d_addr;
  assign di_dec.base = ITCM_BASE;
  assign di_dec.size = itcm_size;
  assign dd_dec.addr = d_addr;
  assign dd_dec.base = dtcm_base;
  assign dd_dec.size = dtcm_size;

  tcsc_range_dec u_dec_i  (.d(i_dec.decoder));
  tcsc_range_dec u_dec_di (.d(di_dec.decoder));
  tcsc_range_dec u_dec_dd (.d(dd_dec.decoder));

  ////////////////////////////////////////////////////////////////////////////
  // routing decisions
  logic i_use_itcm;
  logic d_use_itcm;
  logic d_use_dtcm;
  logic d_hits_i;
  logic d_hits_d;
  logic d_wants_i;

  always_comb begin
    // load mode blocks reads only, so a fetch never uses the array then
    i_use_itcm = i_req && i_dec.hit && ien && !ild;
    // the instruction range is decoded first when both ranges overlap
    d_hits_i   = di_dec.hit && ien;
    d_hits_d   = !d_hits_i && dd_dec.hit && den;
    d_wants_i  = d_req && d_hits_i && (d_wr || !ild);
    d_use_dtcm = d_req && d_hits_d && (d_wr || !dld);
    d_use_itcm = d_wants_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction array port sharing: data side wins, fetch stalls a cycle
  logic i_grant;
  always_comb begin
    i_grant   = i_use_itcm && !d_use_itcm;
    isr_cs    = i_grant || d_use_itcm;
    isr_we    = d_use_itcm && d_wr;
    isr_addr  = d_use_itcm ? d_addr : i_addr;
    isr_wdata = d_wdata;
    isr_be    = d_use_itcm ? d_be : 4'hF;
    dsr_cs    = d_use_dtcm;
    dsr_we    = d_use_dtcm && d_wr;
    dsr_addr  = d_addr;
    dsr_wdata = d_wdata;
    dsr_be    = d_be;
    // disabled memories see no chip select, so contents are retained
    i_ext     = i_req && !i_use_itcm;
    d_ext     = d_req && !d_use_itcm && !d_use_dtcm;
    d_stall   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read return select, one cycle after the array is addressed
  tcsc_src_t i_src_reg;
  tcsc_src_t i_src_next;
  tcsc_src_t d_src_reg;
  tcsc_src_t d_src_next;
  logic      i_wait_reg;
  logic      i_wait_next;
  logic      d_rd_reg;
  logic      d_rd_next;
  logic      i_rd_reg;
  logic      i_rd_next;

  always_comb begin
    i_src_next  = i_src_reg;
    d_src_next  = d_src_reg;
    i_wait_next = i_wait_reg;
    i_rd_next   = i_rd_reg;
    d_rd_next   = d_rd_reg;
    if (clk_en) begin
      i_rd_next   = i_grant;
      i_src_next  = i_grant ? TCSC_SRC_ITCM : TCSC_SRC_EXT;
      d_rd_next   = (d_use_itcm || d_use_dtcm) && !d_wr;
      d_src_next  = d_use_itcm ? TCSC_SRC_ITCM :
                    (d_use_dtcm ? TCSC_SRC_DTCM : TCSC_SRC_EXT);
      i_wait_next = i_use_itcm && d_use_itcm;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      i_src_reg  <= TCSC_SRC_EXT;
      d_src_reg  <= TCSC_SRC_EXT;
      i_wait_reg <= 1'b0;
      i_rd_reg   <= 1'b0;
      d_rd_reg   <= 1'b0;
    end else begin
      i_src_reg  <= i_src_next;
      d_src_reg  <= d_src_next;
      i_wait_reg <= i_wait_next;
      i_rd_reg   <= i_rd_next;
      d_rd_reg   <= d_rd_next;
    end
  end

  // array read data is single cycle, so it is steered straight through
  assign i_rdata = (i_rd_reg && (i_src_reg == TCSC_SRC_ITCM)) ? isr_rdata
                                                              : DATA_RESET;
  always_comb begin
    d_rdata = DATA_RESET;
    // a write leaves no read behind, so the port shows zero, not stale array data
    if (d_rd_reg) begin
      unique case (d_src_reg)
        TCSC_SRC_ITCM: d_rdata = isr_rdata;
        TCSC_SRC_DTCM: d_rdata = dsr_rdata;
        default:       d_rdata = DATA_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: fetch held off while the data port owns the instruction array
  logic i_hold;
  assign i_hold    = i_use_itcm && d_use_itcm;
  assign itcm_on   = ien;
  assign itcm_load = ien && ild;
  assign dtcm_on   = den;
  assign dtcm_load = den && dld;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_dread_itcm;
    d_req && !d_wr && di_dec.hit && ien && !ild;
  endsequence

  sequence s_ret_itcm;
    d_src_reg == TCSC_SRC_ITCM;
  endsequence

  sequence s_dread_dtcm;
    d_req && !d_wr && d_hits_d && !dld;
  endsequence

  sequence s_ret_dtcm;
    d_src_reg == TCSC_SRC_DTCM;
  endsequence

  a_ifetch_off_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (i_req && !ien) |-> (i_ext && !i_grant))
    else $error("fetch with instruction memory off did not go external");

  a_iload_no_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && !d_wr && ild && ien && di_dec.hit) |-> (d_ext && !isr_cs))
    else $error("read in instruction load mode reached the array");

  a_iload_write_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && d_wr && ien && di_dec.hit) |-> (isr_we && isr_addr == d_addr))
    else $error("write to instruction range did not reach the array");

  a_dload_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && den && dld && dd_dec.hit && !di_dec.hit)
      |-> (d_wr ? dsr_we : (d_ext && !dsr_cs)))
    else $error("data load mode routing wrong");

  a_doff_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && !den && !(ien && di_dec.hit)) |-> (d_ext && !dsr_cs))
    else $error("data access with data memory off not external");

  a_den_serve: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && den && !dld && dd_dec.hit && !(ien && di_dec.hit)) |-> dsr_cs)
    else $error("data memory enabled but not selected");

  a_dret_itcm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_dread_itcm and (clk_en == 1'b1)) |=> (s_ret_itcm and (d_rdata == isr_rdata)))
    else $error("instruction array data not returned to data port");

  a_dret_dtcm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_dread_dtcm and (clk_en == 1'b1)) |=> (s_ret_dtcm and (d_rdata == dsr_rdata)))
    else $error("data array data not returned to data port");

  a_ien_serve: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (i_req && ien && !ild && i_dec.hit && !d_req && clk_en)
      |-> (isr_cs && !isr_we && isr_addr == i_addr)
      ##1 (i_rdata == isr_rdata))
    else $error("enabled fetch not served by instruction array");

  a_disable_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!ien) |-> !isr_cs)
    else $error("disabled instruction array was selected");

  a_ctrl_masks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((ctrl_word & CTRL_ILOAD_MASK) == CTRL_ILOAD_MASK) |-> itcm_load)
    else $error("instruction load mask did not set load mode");

  a_dmask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((ctrl_word & CTRL_DLOAD_MASK) == CTRL_DLOAD_MASK) |-> dtcm_load)
    else $error("data load mask did not set load mode");

  a_ibase_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (itcm_size == 5'h0C && i_addr[ADDR_W-1:12] != '0) |-> !i_dec.hit)
    else $error("instruction range not decoded at base zero");

  a_hold_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (i_hold && clk_en) |=> i_wait_reg)
    else $error("shared array conflict not recorded");

  ////////////////////////////////////////////////////////////////////////////
  // size codes, port sharing, read data after a write and the clock enable
  a_fetch_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (i_use_itcm && d_use_itcm) |-> (!i_grant && !i_ext && isr_addr == d_addr))
    else $error("fetch not held off while data port owns instruction array");

  a_isize_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((itcm_size == '0) || (itcm_size > SZ_MAX)) |-> (!i_dec.hit && !di_dec.hit))
    else $error("instruction range decoded with an empty size code");

  a_dsize_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((dtcm_size == '0) || (dtcm_size > SZ_MAX)) |-> !dd_dec.hit)
    else $error("data range decoded with an empty size code");

  a_dwrite_no_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (d_req && d_wr && clk_en) |=> (d_rdata == DATA_RESET))
    else $error("write left read data on the data port");

  a_freeze_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!clk_en) |=> ($stable(i_src_reg) && $stable(d_src_reg)
                   && $stable(i_rd_reg) && $stable(d_rd_reg)))
    else $error("return select moved while the clock enable was low");
endmodule : tcsc_ctrl

/* bench/tcsc_sram_model.sv */
// bench: single-cycle synchronous sram array standing behind one tcm port
`timescale 1ns/10ps
module tcsc_sram_model (
  input  wire logic        clk_sys,
  input  wire logic        cs,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  be,
  output logic      [31:0] rdata
);
  logic [31:0] mem [0:1023];
  // idle output toggles so a stale word can pass for a fresh read only after an even number of idle cycles
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (cs && we && be[i]) begin
        mem[addr[11:2]][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    rdata <= (cs && !we) ? mem[addr[11:2]] : ~rdata;
  end
endmodule : tcsc_sram_model

/* bench/tcsc_ctrl_tb_top.sv */
// bench: top level checking the routing of core accesses to the two tcms
`timescale 1ns/10ps
module tcsc_ctrl_tb_top;
  import tcsc_pkg::*;
  localparam logic [ADDR_W-1:0] D_BASE = 32'h0010_0000;
  localparam logic [CTRL_W-1:0] EN_BOTH = 32'h0005_0000;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [CTRL_W-1:0] ctrl = CTRL_RESET;
  logic              i_req = 1'b0;
  logic              d_req = 1'b0;
  logic              d_wr = 1'b0;
  logic [31:0]       i_addr = 32'h0000_0000;
  logic [31:0]       d_addr = 32'h0000_0000;
  logic [31:0]       d_wdata = 32'h0000_0000;
  logic [31:0]       i_rdata, d_rdata, isr_addr, isr_wdata, isr_rdata;
  logic [31:0]       dsr_addr, dsr_wdata, dsr_rdata;
  logic [3:0]        isr_be, dsr_be;
  logic              i_ext, d_ext, isr_cs, isr_we, dsr_cs, dsr_we;
  logic              itcm_on, itcm_load, dtcm_on, dtcm_load;
  logic [31:0]       lfsr = 32'h0000_0042;
  logic [31:0]       shadow [2048];
  logic              clk_en = 1'b1;
  logic              d_stall;
  logic [SZ_W-1:0]   isize = 5'h0c;
  logic [SZ_W-1:0]   dsize = 5'h0c;
  logic [31:0]       a [4];
  logic [31:0]       b [4];
  int                failures = 0;
  int                samples_checked = 0;

  tcsc_ctrl u_tcsc_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ctrl_word(ctrl),
    .itcm_size(isize), .dtcm_base(D_BASE), .dtcm_size(dsize), .i_req(i_req), .i_addr(i_addr),
    .i_rdata(i_rdata), .i_ext(i_ext), .d_req(d_req), .d_wr(d_wr), .d_addr(d_addr),
    .d_wdata(d_wdata), .d_be(4'hf), .d_rdata(d_rdata), .d_ext(d_ext), .d_stall(d_stall),
    .isr_cs(isr_cs), .isr_we(isr_we), .isr_addr(isr_addr), .isr_wdata(isr_wdata),
    .isr_be(isr_be), .isr_rdata(isr_rdata), .dsr_cs(dsr_cs), .dsr_we(dsr_we),
    .dsr_addr(dsr_addr), .dsr_wdata(dsr_wdata), .dsr_be(dsr_be), .dsr_rdata(dsr_rdata),
    .itcm_on(itcm_on), .itcm_load(itcm_load), .dtcm_on(dtcm_on), .dtcm_load(dtcm_load));
  tcsc_sram_model u_tcsc_sram_model_i (.clk_sys(clk_sys), .cs(isr_cs), .we(isr_we),
    .addr(isr_addr), .wdata(isr_wdata), .be(isr_be), .rdata(isr_rdata));
  tcsc_sram_model u_tcsc_sram_model_d (.clk_sys(clk_sys), .cs(dsr_cs), .we(dsr_we),
    .addr(dsr_addr), .wdata(dsr_wdata), .be(dsr_be), .rdata(dsr_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // bench word store: bit 20 tells the data range from the instruction range
  function automatic logic [10:0] sidx(input logic [31:0] ad);
    return {ad[20], ad[11:2]};
  endfunction : sidx

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one access: routing flags checked in its cycle, read data one cycle later
  task automatic acc(input logic fet, input logic wr, input logic [31:0] ad, input logic ext);
    logic [31:0] wd;
    logic        hi;
    wd = rnd();
    hi = (ad < 32'h0000_1000);
    @(negedge clk_sys);
    i_req = fet;
    i_addr = ad;
    d_req = !fet;
    d_wr = wr;
    d_addr = ad;
    d_wdata = wd;
    #1;
    check({31'h0, fet ? i_ext : d_ext}, {31'h0, ext});
    check({30'h0, hi ? isr_cs : dsr_cs, hi ? isr_we : dsr_we}, {30'h0, !ext, wr && !ext});
    check({31'h0, d_stall}, 32'h0000_0000);
    @(negedge clk_sys);
    i_req = 1'b0;
    d_req = 1'b0;
    if (wr && !ext) shadow[sidx(ad)] = wd;
    if (!wr && !ext) check(fet ? i_rdata : d_rdata, shadow[sidx(ad)]);
  endtask : acc

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #200_000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    ctrl = ctrl | EN_BOTH;
    #1 check({28'h0, itcm_on, itcm_load, dtcm_on, dtcm_load}, 32'h0000_000a);
    for (int k = 0; k < 4; k++) begin
      a[k] = rnd() & 32'h0000_0ffc;
      if (k == 0) a[k] = 32'h0000_0ffc;
      b[k] = D_BASE | (rnd() & 32'h0000_0ffc);
      acc(1'b0, 1'b1, a[k], 1'b0);
      acc(1'b0, 1'b0, a[k], 1'b0);
      acc(1'b1, 1'b0, a[k], 1'b0);
      acc(1'b0, 1'b1, b[k], 1'b0);
      acc(1'b0, 1'b0, b[k], 1'b0);
    end
    acc(1'b0, 1'b0, 32'h0000_1000, 1'b1);
    acc(1'b0, 1'b0, D_BASE + 32'h0000_1000, 1'b1);
    // data port and fetch both want the instruction array: data wins, fetch retries
    @(negedge clk_sys);
    i_req = 1'b1;
    i_addr = a[1];
    d_req = 1'b1;
    d_wr = 1'b0;
    d_addr = a[2];
    #1 check({30'h0, isr_cs, i_ext}, 32'h0000_0002);
    check(isr_addr, a[2]);
    @(negedge clk_sys);
    check(d_rdata, shadow[sidx(a[2])]);
    check(i_rdata, DATA_RESET);
    d_req = 1'b0;
    @(negedge clk_sys);
    check(i_rdata, shadow[sidx(a[1])]);
    i_req = 1'b0;
    $display("test enabled routing done");
    ctrl = ctrl | CTRL_ILOAD_MASK | CTRL_DLOAD_MASK;
    #1 check({28'h0, itcm_on, itcm_load, dtcm_on, dtcm_load}, 32'h0000_000f);
    // image copy: each read goes out, the write to the same address lands in the tcm
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, 1'b0, a[k], 1'b1);
      acc(1'b0, 1'b1, a[k], 1'b0);
      acc(1'b1, 1'b0, a[k], 1'b1);
      acc(1'b0, 1'b0, b[k], 1'b1);
      acc(1'b0, 1'b1, b[k], 1'b0);
    end
    $display("test load mode done");
    ctrl = ctrl & ~(CTRL_ILOAD_MASK | CTRL_DLOAD_MASK);
    acc(1'b1, 1'b0, a[0], 1'b1);
    acc(1'b0, 1'b1, b[0], 1'b1);
    acc(1'b0, 1'b0, b[1], 1'b1);
    acc(1'b0, 1'b1, a[1], 1'b1);
    ctrl = ctrl | EN_BOTH;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 1'b0, a[k], 1'b0);
      acc(1'b0, 1'b0, b[k], 1'b0);
    end
    $display("test disable and retain done");
    // clock enable low freezes the return select, so the fetched word stays hidden
    @(negedge clk_sys);
    clk_en = 1'b0;
    i_req = 1'b1;
    i_addr = a[0];
    @(negedge clk_sys);
    check(i_rdata, DATA_RESET);
    clk_en = 1'b1;
    @(negedge clk_sys);
    check(i_rdata, shadow[sidx(a[0])]);
    i_req = 1'b0;
    // an empty or oversize size code maps no memory at all
    isize = 5'h00;
    dsize = 5'h15;
    acc(1'b1, 1'b0, a[1], 1'b1);
    acc(1'b0, 1'b0, b[1], 1'b1);
    $display("test clock enable and size codes done");
    report_and_stop();
  end
endmodule : tcsc_ctrl_tb_top
